// file: pdz_top.sv
// Implementation choices: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
// How it works
// - Six channels, own duty, shared period counter
// - Duty compare covers all 65536 levels
// - Pulse clock: system, oscillator, doubled oscillator capped at system clock rate
// - High bytes direct, low bytes via buffer
// - Buffer transfers only on high-byte access
// - Enable low clears and stops all channels
// - Output drops when counter equals duty
// - High-byte write updates value immediately
// - One shared flag set each period end
// - Only channel 0 has pair and dead-zone
// - Channel 0 has four modes, mode 0 reset
// - Non-overlap 0 to 15 pulse clocks
// - Pin shows channel only when selected
// - Frequency clock/(period+1), duty fraction duty/(period+1)
// - Writing FDh to flag register clears flag
// - Mode field binary 00 to 11
module pdz_top (
  input  wire logic        CLOCK,
  input  wire logic        SYS_RST,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [9:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  output logic             CH0_POSITIVE_OUT,
  output logic             CH0_NEGATIVE_OUT,
  output logic      [4:0]  SINGLE_CHANNEL_OUT,
  output logic      [6:0]  PIN_OE,
  output logic             PERIOD_END_FLAG
);

  localparam int N = pdz_pkg::NUM_CH;

  function automatic logic idx_hit(input logic [7:0] a, input logic [7:0] i);
    return a == i;
  endfunction : idx_hit

  // Bus decode
  logic              ack_q;
  logic [31:0]       rdata_q;
  wire  [7:0]        idx      = WB_ADR_I[9:2];
  wire               req      = WB_CYC_I & WB_STB_I & ~ack_q;
  wire               wr       = req & WB_WE_I & WB_SEL_I[0];
  wire               rd       = req & ~WB_WE_I;
  wire  [7:0]        wbyte    = WB_DAT_I[7:0];
  wire               hit_flag = idx_hit(idx, pdz_pkg::IDX_FLAG);
  wire               hit_ctl  = idx_hit(idx, pdz_pkg::IDX_CTL);
  wire               hit_cks  = idx_hit(idx, pdz_pkg::IDX_CKSEL);
  wire               hit_ph   = idx_hit(idx, pdz_pkg::IDX_PRD_HIGH);
  wire               hit_pl   = idx_hit(idx, pdz_pkg::IDX_PRD_LOW);
  wire               hit_pin  = idx_hit(idx, pdz_pkg::IDX_PINSEL);
  logic [N-1:0]      hit_dh;
  logic [N-1:0]      hit_dl;

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_dec
      assign hit_dh[g] = idx_hit(idx, 8'(pdz_pkg::IDX_DUTY0_HI + 2 * g));
      assign hit_dl[g] = idx_hit(idx, 8'(pdz_pkg::IDX_DUTY0_HI + 2 * g + 1));
    end
  endgenerate

  wire any_low_wr  = wr & (hit_pl | (|hit_dl));

  // Registers
  pdz_pkg::pdz_ctl_t ctl_q;
  pdz_pkg::pdz_cks_t cks_q;
  logic [15:0]       prd_q;
  logic [15:0]       duty_q [N];
  logic [7:0]        hold_q;
  logic [6:0]        pinsel_q;
  logic              flag_q;
  logic [15:0]       cnt_q;
  logic [5:0]        acc_q;
  logic [N-1:0]      raw;
  logic              ch0_pos;
  logic              ch0_neg;

  // Control byte and pin selection
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ctl_q    <= '0;
      cks_q    <= pdz_pkg::CKS_SYS0;
      pinsel_q <= 7'h00;
    end else begin
      if (wr && hit_ctl) begin
        ctl_q.en   <= wbyte[pdz_pkg::CTL_EN_BIT];
        ctl_q.mode <= pdz_pkg::pdz_mode_t'(wbyte[pdz_pkg::CTL_MODE_LSB +: 2]);
        ctl_q.dz   <= wbyte[pdz_pkg::CTL_DZ_LSB +: 4];
      end
      if (wr && hit_cks)
        cks_q <= pdz_pkg::pdz_cks_t'(wbyte[pdz_pkg::CKS_LSB +: 2]);
      if (wr && hit_pin)
        pinsel_q <= wbyte[6:0];
    end
  end

  // Shared low-byte holding buffer
  logic [7:0] hold_d;
  always_comb begin
    hold_d = hold_q;
    if (any_low_wr)
      hold_d = wbyte;
    else if (rd && hit_ph)
      hold_d = prd_q[7:0];
    for (int i = 0; i < N; i++) begin
      if (rd && hit_dh[i])
        hold_d = duty_lo_b[i];
    end
  end

  // Byte views of each duty value for read-back and buffer loading
  logic [7:0] duty_hi_b [N];
  logic [7:0] duty_lo_b [N];
  generate
    for (g = 0; g < N; g++) begin : g_rb
      assign duty_hi_b[g] = duty_q[g][15:8];
      assign duty_lo_b[g] = duty_q[g][7:0];
    end
  endgenerate

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST)
      hold_q <= pdz_pkg::BYTE_RESET;
    else
      hold_q <= hold_d;
  end

  // A high-byte write loads the full value at once
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      prd_q <= pdz_pkg::PRD_RESET;
      for (int i = 0; i < N; i++)
        duty_q[i] <= pdz_pkg::DUTY_RESET;
    end else begin
      if (wr && hit_ph)
        prd_q <= {wbyte, hold_q};
      for (int i = 0; i < N; i++) begin
        if (wr && hit_dh[i])
          duty_q[i] <= {wbyte, hold_q};
      end
    end
  end

  // Pulse clock enable: fractional accumulator over the system clock
  logic [5:0] step;
  always_comb begin
    unique case (cks_q)
      pdz_pkg::CKS_SYS0,
      pdz_pkg::CKS_SYS1:  step = pdz_pkg::STEP_SYS;
      pdz_pkg::CKS_FAST_INTERNAL_OSC:  step = pdz_pkg::STEP_FAST_INTERNAL_OSC;
      pdz_pkg::CKS_FIRC2: step = pdz_pkg::STEP_FIRC2;
    endcase
  end

  wire [5:0] acc_sum = acc_q + step;
  wire       tick    = acc_sum >= pdz_pkg::STEP_MOD;
  wire [5:0] acc_d   = tick ? acc_sum - pdz_pkg::STEP_MOD : acc_sum;

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST)
      acc_q <= 6'h00;
    else
      acc_q <= acc_d;
  end

  // Base counter runs 0..period; a period shortened below the count also wraps
  wire        wrap  = ctl_q.en & tick & (cnt_q >= prd_q);
  logic [15:0] cnt_d;
  always_comb begin
    cnt_d = cnt_q;
    if (!ctl_q.en)
      cnt_d = 16'h0000;
    else if (wrap)
      cnt_d = 16'h0000;
    else if (tick)
      cnt_d = cnt_q + 16'h0001;
  end

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST)
      cnt_q <= 16'h0000;
    else
      cnt_q <= cnt_d;
  end

  // Period-end flag; a wrap in the same cycle as a clear keeps it set
  wire flag_clr = wr & hit_flag & ~wbyte[pdz_pkg::FLAG_BIT];
  logic flag_d;
  always_comb begin
    flag_d = flag_q;
    if (wrap)
      flag_d = 1'b1;
    else if (flag_clr)
      flag_d = 1'b0;
  end

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST)
      flag_q <= 1'b0;
    else
      flag_q <= flag_d;
  end

  // High from rollover until count equals duty; duty zero stays low
  generate
    for (g = 0; g < N; g++) begin : g_cmp
      assign raw[g] = ctl_q.en & (cnt_q < duty_q[g]);
    end
  endgenerate

  pdz_dead_zone u_dz (
    .clk    (CLOCK),
    .rst    (SYS_RST),
    .tick   (tick),
    .enable (ctl_q.en),
    .raw    (raw[0]),
    .dz     (ctl_q.dz),
    .mode   (ctl_q.mode),
    .pos    (ch0_pos),
    .neg    (ch0_neg)
  );

  // Read-back images of the small registers
  wire [7:0] flag_byte = {6'h00, flag_q, 1'b0};
  wire [7:0] ctl_byte  = {ctl_q.en, 1'b0, ctl_q.mode, ctl_q.dz};
  wire [7:0] cks_byte  = {2'b00, cks_q, 4'h0};
  wire [7:0] pin_byte  = {1'b0, pinsel_q};

  // Read data
  logic [7:0] rbyte;
  always_comb begin
    rbyte = 8'h00;
    if (hit_flag)
      rbyte = flag_byte;
    else if (hit_ctl)
      rbyte = ctl_byte;
    else if (hit_cks)
      rbyte = cks_byte;
    else if (hit_pin)
      rbyte = pin_byte;
    else if (hit_ph)
      rbyte = prd_q[15:8];
    else if (hit_pl)
      rbyte = hold_q;
    for (int i = 0; i < N; i++) begin
      if (hit_dh[i])
        rbyte = duty_hi_b[i];
      else if (hit_dl[i])
        rbyte = hold_q;
    end
  end

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q   <= req;
      rdata_q <= rd ? {24'h000000, rbyte} : 32'h0000_0000;
    end
  end

  // Pin stage: channel function reaches a pin only when selected
  logic [6:0] pins_q;
  logic [6:0] pins_d;
  logic [6:0] pin_src;
  assign pin_src = {raw[5:1], ch0_neg, ch0_pos};

  generate
    for (g = 0; g < 7; g++) begin : g_pin
      assign pins_d[g] = pinsel_q[g] & pin_src[g];
    end
  endgenerate

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pins_q <= 7'h00;
      PIN_OE <= 7'h00;
    end else begin
      pins_q <= pins_d;
      PIN_OE <= pinsel_q;
    end
  end

  assign WB_ACK_O           = ack_q;
  assign WB_DAT_O           = rdata_q;
  assign CH0_POSITIVE_OUT   = pins_q[0];
  assign CH0_NEGATIVE_OUT   = pins_q[1];
  assign SINGLE_CHANNEL_OUT = pins_q[6:2];
  assign PERIOD_END_FLAG    = flag_q;

endmodule : pdz_top

// file: pdz_pkg.sv
package pdz_pkg;

  localparam int NUM_CH = 6;

  // Rates in MHz; the pulse clock is a fractional enable derived from the system clock
  localparam int FSYS_MHZ  = 20;
  localparam int FAST_INTERNAL_OSC_MHZ  = 16;
  localparam int FIRC2_MHZ = 2 * FAST_INTERNAL_OSC_MHZ;
  localparam logic [5:0] STEP_SYS   = 6'(FSYS_MHZ);
  localparam logic [5:0] STEP_FAST_INTERNAL_OSC  = 6'(FAST_INTERNAL_OSC_MHZ < FSYS_MHZ ? FAST_INTERNAL_OSC_MHZ : FSYS_MHZ);
  localparam logic [5:0] STEP_FIRC2 = 6'(FIRC2_MHZ < FSYS_MHZ ? FIRC2_MHZ : FSYS_MHZ);
  localparam logic [5:0] STEP_MOD   = 6'(FSYS_MHZ);

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_FLAG     = 8'h0E;
  localparam logic [7:0] IDX_CTL      = 8'h89;
  localparam logic [7:0] IDX_CKSEL    = 8'h91;
  localparam logic [7:0] IDX_PRD_HIGH = 8'h92;
  localparam logic [7:0] IDX_PRD_LOW  = 8'h93;
  localparam logic [7:0] IDX_DUTY0_HI = 8'h94;
  localparam logic [7:0] IDX_PINSEL   = 8'hA0;

  // Field positions
  localparam int CTL_EN_BIT   = 7;
  localparam int CTL_MODE_LSB = 4;
  localparam int CTL_DZ_LSB   = 0;
  localparam int CKS_LSB      = 4;
  localparam int FLAG_BIT     = 1;

  // Reset values
  localparam logic [15:0] PRD_RESET  = 16'hFFFF;
  localparam logic [15:0] DUTY_RESET = 16'h8000;
  localparam logic [7:0]  BYTE_RESET = 8'h00;

  typedef enum logic [1:0] {
    CKS_SYS0  = 2'b00,
    CKS_SYS1  = 2'b01,
    CKS_FAST_INTERNAL_OSC  = 2'b10,
    CKS_FIRC2 = 2'b11
  } pdz_cks_t;

  typedef enum logic [1:0] {
    MODE0 = 2'b00,
    MODE1 = 2'b01,
    MODE2 = 2'b10,
    MODE3 = 2'b11
  } pdz_mode_t;

  typedef struct packed {
    logic      en;
    pdz_mode_t mode;
    logic [3:0] dz;
  } pdz_ctl_t;

endpackage : pdz_pkg

// file: pdz_dead_zone.sv
`timescale 1ns/1ps
module pdz_dead_zone (
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire logic            tick,
  input  wire logic            enable,
  input  wire logic            raw,
  input  wire logic [3:0]      dz,
  input  wire pdz_pkg::pdz_mode_t mode,
  output logic                 pos,
  output logic                 neg
);

  logic       last_q;
  logic [3:0] dcnt_q;
  wire        changed = raw != last_q;
  wire        settled = dcnt_q >= dz;
  wire        p_act   = enable & last_q & settled;
  wire        n_act   = enable & ~last_q & settled;

  // Each level change restarts the non-overlap count in pulse clocks
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      last_q <= 1'b0;
      dcnt_q <= 4'h0;
    end else if (changed) begin
      last_q <= raw;
      dcnt_q <= 4'h0;
    end else if (tick && !settled) begin
      dcnt_q <= dcnt_q + 4'h1;
    end
  end

  // In mode 0 rising edges of both phases wait for the interval; modes 1 to 3 invert one or both
  always_comb begin
    pos = 1'b0;
    neg = 1'b0;
    if (enable) begin
      unique case (mode)
        pdz_pkg::MODE0: begin
          pos = p_act;
          neg = n_act;
        end
        pdz_pkg::MODE1: begin
          pos = ~p_act;
          neg = ~n_act;
        end
        pdz_pkg::MODE2: begin
          pos = p_act;
          neg = ~n_act;
        end
        pdz_pkg::MODE3: begin
          pos = ~p_act;
          neg = n_act;
        end
      endcase
    end
  end

endmodule : pdz_dead_zone

// file: pdz_chk.sv
`timescale 1ns/1ps
module pdz_chk (
  input wire logic        CLOCK,
  input wire logic        SYS_RST,
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_WE_I,
  input wire logic [9:0]  WB_ADR_I,
  input wire logic [3:0]  WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic        WB_ACK_O,
  input wire logic        CH0_POSITIVE_OUT,
  input wire logic        CH0_NEGATIVE_OUT,
  input wire logic [4:0]  SINGLE_CHANNEL_OUT,
  input wire logic [6:0]  PIN_OE,
  input wire logic        PERIOD_END_FLAG
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  wire tk = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  wire fclr = tk & WB_WE_I & WB_SEL_I[0] & ~WB_DAT_I[1] & (WB_ADR_I[9:2] == pdz_pkg::IDX_FLAG);
  a_ack_next: assert property (tk |=> WB_ACK_O) else $error("ack late");
  a_ack_once: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack long");
  a_ack_cause: assert property ($rose(WB_ACK_O) |-> $past(tk)) else $error("ack stray");
  a_dat_idle: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0) else $error("data idle");
  a_dat_upper: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h0) else $error("data upper");
  a_flag_hold: assert property (PERIOD_END_FLAG && !fclr |=> PERIOD_END_FLAG) else $error("flag lost");
  a_flag_clear: assert property ($fell(PERIOD_END_FLAG) |-> $past(fclr)) else $error("flag fell");
  a_pin_gate: assert property (!PIN_OE[0] && !$past(PIN_OE[0]) |-> !CH0_POSITIVE_OUT) else $error("p gate");
  a_single_gate: assert property ((SINGLE_CHANNEL_OUT & ~PIN_OE[6:2] & ~$past(PIN_OE[6:2])) == 5'h0)
    else $error("single gate");
  cover property ($rose(PERIOD_END_FLAG));
  cover property (fclr);
  cover property ($rose(CH0_NEGATIVE_OUT));
endmodule : pdz_chk
bind pdz_top pdz_chk u_chk (.*);

// file: pdz_load.sv
`timescale 1ns/1ps
module pdz_load (
  input  wire logic             clk,
  input  wire logic             clr,
  input  wire logic [6:0]       drv,
  input  wire logic [6:0]       oe,
  output logic      [6:0][15:0] hi_cnt,
  output logic      [15:0]      rise_cnt
);
  // Load pull-downs hold an undriven pin low
  wire [6:0] pin = drv & oe;
  logic [6:0] pin_q;
  always_ff @(posedge clk) begin
    pin_q <= pin;
    rise_cnt <= clr ? 16'h0 : rise_cnt + 16'(pin[0] & ~pin_q[0]);
    for (int i = 0; i < 7; i++) hi_cnt[i] <= clr ? 16'h0 : hi_cnt[i] + 16'(pin[i]);
  end
endmodule : pdz_load

// file: test_six_channel_pwm_dead_zone.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; \
  $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module test_six_channel_pwm_dead_zone;
  logic CLOCK = 0, SYS_RST = 1, cyc = 0, stb = 0, we = 0, clr = 1;
  logic [9:0] adr = '0;
  logic [31:0] wdat = '0, rdat;
  logic ack, p, n, flg;
  logic [4:0] so;
  logic [6:0] oe;
  logic [6:0][15:0] hi;
  logic [15:0] rises;
  logic [7:0] r;
  int failures = 0, samples_checked = 0;
  logic [15:0] duty [6] = '{16'h3, 16'h0, 16'h2, 16'h4, 16'h9, 16'hA};
  logic [15:0] ehi [7] = '{30, 70, 0, 20, 40, 90, 100};
  logic [15:0] mp [4] = '{30, 70, 30, 70};
  logic [15:0] mn [4] = '{70, 30, 30, 70};
  logic [15:0] sr [4] = '{20, 20, 16, 20};
  always #25 CLOCK = ~CLOCK;
  pdz_top dut (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(4'h1), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .CH0_POSITIVE_OUT(p),
    .CH0_NEGATIVE_OUT(n), .SINGLE_CHANNEL_OUT(so), .PIN_OE(oe), .PERIOD_END_FLAG(flg));
  pdz_load u_load (.clk(CLOCK), .clr(clr), .drv({so, n, p}), .oe(oe), .hi_cnt(hi), .rise_cnt(rises));
  task automatic final_report;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report
  task automatic wb(input logic w, input logic [7:0] ix, input logic [7:0] d);
    int k;
    @(posedge CLOCK);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {ix, 2'b00};
    wdat <= {24'h0, d};
    k = 0;
    do begin @(posedge CLOCK); k++; end while (ack !== 1'b1 && k < 20);
    if (k >= 20) begin failures++; final_report(); end
    r = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic rd(input logic [7:0] ix, input logic [7:0] e);
    wb(1'b0, ix, 8'h00);
    `CHK("read", e, r)
  endtask : rd
  // Settle, clear the load counters, then count c cycles
  task automatic meas(input int c);
    repeat (40) @(posedge CLOCK);
    clr <= 1'b1;
    @(posedge CLOCK);
    clr <= 1'b0;
    repeat (c) @(posedge CLOCK);
    #1;
  endtask : meas
  initial begin
    repeat (3) @(posedge CLOCK);
    SYS_RST <= 1'b0;
    rd(8'h92, 8'hFF);
    rd(8'h93, 8'hFF);
    rd(8'h94, 8'h80);
    rd(8'h95, 8'h00);
    rd(8'h89, 8'h00);
    wb(1'b1, 8'h93, 8'h09);
    rd(8'h93, 8'h09);
    rd(8'h92, 8'hFF);
    rd(8'h93, 8'hFF);
    wb(1'b1, 8'h50, 8'hFF);
    rd(8'h50, 8'h00);
    wb(1'b1, 8'h93, 8'h09);
    wb(1'b1, 8'h92, 8'h00);
    for (int i = 0; i < 6; i++) begin
      wb(1'b1, 8'(8'h95 + 2 * i), duty[i][7:0]);
      wb(1'b1, 8'(8'h94 + 2 * i), duty[i][15:8]);
    end
    rd(8'h94, 8'h00);
    rd(8'h95, 8'h03);
    wb(1'b1, 8'hA0, 8'h7F);
    wb(1'b1, 8'h89, 8'h80);
    meas(100);
    for (int i = 0; i < 7; i++) `CHK("pin high", ehi[i], hi[i])
    `CHK("oe", 7'h7F, oe)
    `CHK("flag pin", 1'b1, flg)
    rd(8'h0E, 8'h02);
    wb(1'b1, 8'h0E, 8'hFF);
    rd(8'h0E, 8'h02);
    for (int m = 0; m < 4; m++) begin
      wb(1'b1, 8'h89, 8'(8'h80 | (m << 4)));
      meas(100);
      `CHK("mode p", mp[m], hi[0])
      `CHK("mode n", mn[m], hi[1])
    end
    wb(1'b1, 8'h89, 8'h80);
    for (int s = 0; s < 4; s++) begin
      wb(1'b1, 8'h91, 8'(s << 4));
      meas(200);
      `CHK("rises", sr[s], rises)
    end
    wb(1'b1, 8'h89, 8'h82);
    meas(100);
    `CHK("dz p", 16'd10, hi[0])
    `CHK("dz n", 16'd50, hi[1])
    wb(1'b1, 8'h89, 8'h00);
    meas(20);
    for (int i = 0; i < 7; i++) `CHK("off", 16'd0, hi[i])
    wb(1'b1, 8'h0E, 8'hFD);
    rd(8'h0E, 8'h00);
    `CHK("flag pin", 1'b0, flg)
    final_report();
  end
endmodule : test_six_channel_pwm_dead_zone
